/* sfcd_pkg.sv */
// package of opcodes, decode table and types for the serial flash command decoder
package sfcd_pkg;
    // ==========================================================
    // opcodes
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_FAST_ARRAY_FETCH = 8'h0B;
    localparam logic [7:0] OPC_TWO_LANE_OUT_FETCH = 8'h3B;
    localparam logic [7:0] OPC_TWO_LANE_IO_FETCH = 8'hBB;
    localparam logic [7:0] OPC_FOUR_LANE_OUT_FETCH = 8'h6B;
    localparam logic [7:0] OPC_FOUR_LANE_IO_FETCH = 8'hEB;
    localparam logic [7:0] OPC_FOUR_LANE_WORD_FETCH = 8'hE7;
    localparam logic [7:0] OPC_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OPC_WRITE_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OPC_VOLATILE_STATUS_UNLOCK = 8'h50;
    localparam logic [7:0] OPC_ALL_BLOCK_PROTECT = 8'h7E;
    localparam logic [7:0] OPC_ALL_BLOCK_UNPROTECT = 8'h98;
    localparam logic [7:0] OPC_STATUS_FETCH_PRIMARY = 8'h05;
    localparam logic [7:0] OPC_STATUS_FETCH_SECOND = 8'h35;
    localparam logic [7:0] OPC_CONFIG_FETCH = 8'h15;
    localparam logic [7:0] OPC_IDENTITY_FETCH = 8'h9F;
    localparam logic [7:0] OPC_MAKER_DEVICE_CODE_FETCH = 8'h90;
    localparam logic [7:0] OPC_MAKER_CODE_FETCH_TWO_LANE = 8'h92;
    localparam logic [7:0] OPC_MAKER_CODE_FETCH_FOUR_LANE = 8'h94;
    localparam logic [7:0] OPC_SLEEP_MODE_ENTRY = 8'hB9;
    localparam logic [7:0] OPC_SLEEP_EXIT_AND_ID = 8'hAB;
    localparam logic [7:0] OPC_FOUR_LANE_COMMAND_ENTRY = 8'h38;
    localparam logic [7:0] OPC_ENHANCED_RELEASE = 8'hFF;
    localparam logic [7:0] OPC_SOFT_RESET_ARM = 8'h66;
    localparam logic [7:0] OPC_SOFT_RESET_GO = 8'h99;
    // ==========================================================
    // timing and identity
    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_SOFT_RESET_NS = 30000;
    localparam int SOFT_RESET_CYC = (T_SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] MAKER_CODE = 8'h5A;  // arbitrary value
    localparam logic [15:0] DEVICE_CODE = 16'h1234;  // arbitrary value
    localparam logic [7:0] ELECTRONIC_CODE = 8'h13;  // arbitrary value
    localparam logic [3:0] OE_ONE = 4'h2;
    localparam logic [3:0] OE_TWO = 4'h3;
    localparam logic [3:0] OE_FOUR = 4'hF;
    // ==========================================================
    // types
    typedef enum logic [7:0] {
        S_IDLE = 8'h01, S_OPC = 8'h02, S_ADDR = 8'h04, S_DMY = 8'h08,
        S_DIN = 8'h10, S_DOUT = 8'h20, S_HOLD = 8'h40, S_STBY = 8'h80
    } sfcd_st_t;
    typedef struct packed {
        logic known;
        logic [1:0] an;
        logic [2:0] dn;
        logic [2:0] al;
        logic [2:0] dl;
        logic rd;
        logic wr;
        logic quad;
    } sfcd_dec_t;
    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
    } sfcd_cmd_t;
    // ==========================================================
    // decode table
    function automatic sfcd_dec_t sfcd_decode(input logic [7:0] op, input logic alt);
        sfcd_dec_t d;
        d = '{known: 1'b1, an: 2'h0, dn: 3'h0, al: 3'h1, dl: 3'h1, default: 1'b0};
        case (op)
            8'h03: begin d.an = 2'h3; d.rd = 1'b1; end
            8'h0B: begin d.an = 2'h3; d.dn = 3'h1; d.rd = 1'b1; end
            8'h3B: begin d.an = 2'h3; d.dn = 3'h1; d.dl = 3'h2; d.rd = 1'b1; end
            8'hBB: begin
                d.an = 2'h3; d.dn = alt ? 3'h2 : 3'h1; d.al = 3'h2; d.dl = 3'h2; d.rd = 1'b1;
            end
            8'h6B: begin
                d.an = 2'h3; d.dn = 3'h1; d.dl = 3'h4; d.rd = 1'b1; d.quad = 1'b1;
            end
            8'hEB: begin
                d.an = 2'h3; d.dn = alt ? 3'h5 : 3'h3; d.al = 3'h4; d.dl = 3'h4;
                d.rd = 1'b1; d.quad = 1'b1;
            end
            8'hE7: begin
                d.an = 2'h3; d.dn = 3'h1; d.al = 3'h4; d.dl = 3'h4; d.rd = 1'b1; d.quad = 1'b1;
            end
            8'h81, 8'h20, 8'h52, 8'hD8: d.an = 2'h3;
            8'h60, 8'hC7, 8'h75, 8'h7A: d.an = 2'h0;
            8'h02: begin d.an = 2'h3; d.wr = 1'b1; end
            8'h32: begin d.an = 2'h3; d.wr = 1'b1; d.dl = 3'h4; d.quad = 1'b1; end
            8'h06, 8'h04, 8'h50, 8'h7E, 8'h98: d.an = 2'h0;
            8'h36, 8'h39, 8'h3D, 8'h44: d.an = 2'h3;
            8'h42: begin d.an = 2'h3; d.wr = 1'b1; end
            8'h48, 8'h9B: begin d.an = 2'h3; d.dn = 3'h1; d.rd = 1'b1; end
            8'h05, 8'h35, 8'h15, 8'h9F: d.rd = 1'b1;
            8'h01, 8'h31, 8'h11: d.wr = 1'b1;
            8'h9E, 8'h66, 8'h99, 8'h38, 8'hFF, 8'hB9: d.an = 2'h0;
            8'h9A, 8'h9D: d.an = 2'h3;
            8'h9C: begin d.an = 2'h3; d.wr = 1'b1; end
            8'h90, 8'hAB: begin d.an = 2'h3; d.rd = 1'b1; end
            8'h92: begin d.an = 2'h3; d.dn = 3'h1; d.dl = 3'h2; d.rd = 1'b1; end
            8'h94: begin
                d.an = 2'h3; d.dn = 3'h1; d.dl = 3'h4; d.rd = 1'b1; d.quad = 1'b1;
            end
            default: d.known = 1'b0;
        endcase
        return d;
    endfunction : sfcd_decode
endpackage : sfcd_pkg

/* sfcd_decoder.sv */
// serial flash command decoder, device side of the serial link
`timescale 1ns/1ps
// Summary of operation
// - 03h/0Bh reads, three address, 0Bh one dummy
// - 3Bh two-lane output read, one dummy
// - BBh two-lane address and data, 1(2) dummy
// - 6Bh four-lane output read, one dummy
// - EBh four-lane address and data, 3(5) dummy
// - E7h four-lane word read, one dummy
// - 81h/20h/52h erases take three address bytes
// - D8h erases 64K; 60h/C7h erase all
// - 02h program single lane; 32h four lanes
// - 75h suspends, 7Ah resumes, no payload
// - 06h sets, 04h clears latch; 50h unlocks
// - 36h/39h/3Dh take three block address bytes
// - 7Eh protects all blocks, 98h unprotects
// - security 44h/42h address; 48h adds dummy
// - 05h/35h/15h return one status or configuration byte
// - 01h/31h/11h write status or configuration
// - 9Eh clears buffer, 9Ah loads buffer
// - 9Bh/9Ch/9Dh buffer read, write, commit
// - 9Fh returns maker then two device bytes
// - 90h/92h/94h code reads, address, lane width
// - B9h sleeps; ABh wakes and returns code
// - FFh leaves enhanced mode; 38h four-lane commands
// - 66h then 99h resets; busy 30us
// - chip select off byte boundary discards command
// - unknown opcode idles output until next frame
// - four-lane commands need quad permit bit
module sfcd_decoder
    import sfcd_pkg::*;
#(
    parameter int RESET_CYC = SOFT_RESET_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic quad_lane_permit_bit,
    input wire logic alt_dummy,
    input wire logic [7:0] stat_primary,
    input wire logic [7:0] stat_second,
    input wire logic [7:0] config_byte,
    input wire logic [7:0] rd_byte,
    output logic rd_next,
    output logic cmd_valid,
    output sfcd_cmd_t cmd,
    output logic wr_valid,
    output logic [7:0] wr_byte,
    input wire logic wr_ready,
    output logic overrun,
    output logic write_latch,
    output logic vsr_unlock,
    output logic all_protect,
    output logic sleeping,
    output logic four_lane_cmd,
    output logic busy
);
    // ==========================================================
    // state
    typedef struct packed {
        logic sclk_m, sclk_r, sclk_p;
        logic cs_m, cs_r, cs_p;
        logic [3:0] io_m, io_r;
        sfcd_st_t st;
        sfcd_dec_t dec;
        logic [7:0] opc;
        logic [23:0] addr;
        logic [7:0] sh;
        logic [2:0] lane;
        logic [2:0] cnt;
        logic [2:0] bcnt;
        logic [1:0] oidx;
        logic [3:0] out;
        logic [3:0] oe;
        logic rd_next;
        logic cmd_vld;
        logic arm;
        logic wel;
        logic vsr;
        logic prot;
        logic sleep;
        logic qmode;
        logic ovr;
        logic busy;
        logic [15:0] bsy_cnt;
        logic hv;
        logic tv;
        logic [7:0] hd;
        logic [7:0] td;
    } sfcd_state_t;

    sfcd_state_t q, n;

    function automatic logic [2:0] last_beat(input logic [2:0] w);
        return (w == 3'h4) ? 3'h1 : (w == 3'h2) ? 3'h3 : 3'h7;
    endfunction : last_beat

    // next state after the opcode (0), address (1) or dummy (2) phase
    function automatic sfcd_st_t after(input sfcd_dec_t d, input logic [1:0] ph);
        if (ph == 2'h0 && d.an != 2'h0) return S_ADDR;
        if (ph != 2'h2 && d.dn != 3'h0) return S_DMY;
        if (d.rd) return S_DOUT;
        if (d.wr) return S_DIN;
        return S_HOLD;
    endfunction : after

    logic rise;
    logic fall;
    logic cs_rise;
    logic ex_ok;
    logic last;
    logic [7:0] ib;
    logic [7:0] ob;
    logic [7:0] src;
    sfcd_dec_t d;

    assign rise = q.sclk_r & ~q.sclk_p;
    assign fall = ~q.sclk_r & q.sclk_p;
    assign cs_rise = q.cs_r & ~q.cs_p;
    assign ex_ok = cs_rise && (q.st == S_HOLD || q.st == S_DIN) && q.cnt == 3'h0;
    assign last = q.cnt == last_beat(q.lane);

    // ==========================================================
    // next state
    always_comb begin
        n = q;
        n.sclk_m = sclk;
        n.sclk_r = q.sclk_m;
        n.sclk_p = q.sclk_r;
        n.cs_m = cs_n;
        n.cs_r = q.cs_m;
        n.cs_p = q.cs_r;
        n.io_m = io_in;
        n.io_r = q.io_m;
        n.cmd_vld = 1'b0;
        n.rd_next = 1'b0;
        d = sfcd_decode(8'h00, alt_dummy);
        ib = 8'h00;
        ob = 8'h00;
        src = rd_byte;
        if (q.bsy_cnt != 16'h0) begin
            n.bsy_cnt = q.bsy_cnt - 16'h1;
        end
        n.busy = n.bsy_cnt != 16'h0;
        // drain side of the two-entry write buffer
        if (q.hv && wr_ready) begin
            n.hv = q.tv;
            n.hd = q.td;
            n.tv = 1'b0;
        end
        // bits in, most significant first
        case (q.lane)
            3'h4: ib = {q.sh[3:0], q.io_r[3:0]};
            3'h2: ib = {q.sh[5:0], q.io_r[1:0]};
            default: ib = {q.sh[6:0], q.io_r[0]};
        endcase
        if (q.cs_r) begin
            if (ex_ok) begin
                n.cmd_vld = 1'b1;
                n.arm = q.opc == OPC_SOFT_RESET_ARM;
                case (q.opc)
                    OPC_WRITE_LATCH_SET: n.wel = 1'b1;
                    OPC_WRITE_LATCH_CLEAR: n.wel = 1'b0;
                    OPC_VOLATILE_STATUS_UNLOCK: n.vsr = 1'b1;
                    OPC_ALL_BLOCK_PROTECT: n.prot = 1'b1;
                    OPC_ALL_BLOCK_UNPROTECT: n.prot = 1'b0;
                    OPC_SLEEP_MODE_ENTRY: n.sleep = 1'b1;
                    OPC_FOUR_LANE_COMMAND_ENTRY: n.qmode = 1'b1;
                    OPC_ENHANCED_RELEASE: n.qmode = 1'b0;
                    OPC_SOFT_RESET_GO: begin
                        if (q.arm) begin
                            n.bsy_cnt = 16'(RESET_CYC);
                            n.busy = 1'b1;
                            n.wel = 1'b0;
                            n.vsr = 1'b0;
                            n.qmode = 1'b0;
                        end
                    end
                    default: n.arm = n.arm;
                endcase
            end
            if (cs_rise && q.opc == OPC_SLEEP_EXIT_AND_ID
                && (q.st == S_DOUT || (q.st == S_ADDR && q.bcnt == 3'h0 && q.cnt == 3'h0))) begin
                n.sleep = 1'b0;
            end
            n.st = S_IDLE;
            n.oe = 4'h0;
            n.out = 4'h0;
        end else if (q.st == S_IDLE) begin
            n.st = q.busy ? S_STBY : S_OPC;
            n.cnt = 3'h0;
            n.bcnt = 3'h0;
            n.lane = 3'h1;
            n.oidx = 2'h0;
            n.addr = 24'h0;
        end else if (rise && q.st != S_DOUT && q.st != S_STBY) begin
            n.sh = ib;
            n.cnt = last ? 3'h0 : q.cnt + 3'h1;
            if (last) begin
                case (q.st)
                    S_OPC: begin
                        d = sfcd_decode(ib, alt_dummy);
                        n.opc = ib;
                        n.dec = d;
                        n.st = after(d, 2'h0);
                        if (!d.known || (q.sleep && ib != OPC_SLEEP_EXIT_AND_ID)) begin
                            n.st = S_STBY;
                        end
                        if (d.quad && !quad_lane_permit_bit) begin
                            n.st = S_STBY;
                        end
                    end
                    S_ADDR: begin
                        n.addr = {q.addr[15:0], ib};
                        n.bcnt = q.bcnt + 3'h1;
                        if (q.bcnt == 3'h2) begin
                            n.st = after(q.dec, 2'h1);
                            n.bcnt = 3'h0;
                        end
                    end
                    S_DMY: begin
                        n.bcnt = q.bcnt + 3'h1;
                        if (n.bcnt == q.dec.dn) begin
                            n.st = after(q.dec, 2'h2);
                        end
                    end
                    S_DIN: begin
                        if (!n.hv) begin
                            n.hd = ib;
                            n.hv = 1'b1;
                        end else if (!n.tv) begin
                            n.td = ib;
                            n.tv = 1'b1;
                        end else begin
                            n.ovr = 1'b1;
                        end
                    end
                    default: n.st = q.st;
                endcase
                if (n.st == S_ADDR || n.st == S_DMY) begin
                    n.lane = n.dec.al;
                end
                if (n.st == S_DIN || n.st == S_DOUT) begin
                    n.lane = n.dec.dl;
                end
                if (n.st == S_DOUT) begin
                    n.cmd_vld = 1'b1;
                end
            end
        end else if (fall && q.st == S_DOUT) begin
            case (q.opc)
                OPC_STATUS_FETCH_PRIMARY: src = stat_primary;
                OPC_STATUS_FETCH_SECOND: src = stat_second;
                OPC_CONFIG_FETCH: src = config_byte;
                OPC_IDENTITY_FETCH: begin
                    case (q.oidx)
                        2'h0: src = MAKER_CODE;
                        2'h1: src = DEVICE_CODE[15:8];
                        2'h2: src = DEVICE_CODE[7:0];
                        default: src = 8'h00;
                    endcase
                end
                OPC_MAKER_DEVICE_CODE_FETCH, OPC_MAKER_CODE_FETCH_TWO_LANE,
                OPC_MAKER_CODE_FETCH_FOUR_LANE: begin
                    src = (q.addr[0] ^ q.oidx[0]) ? DEVICE_CODE[7:0] : MAKER_CODE;
                end
                OPC_SLEEP_EXIT_AND_ID: src = ELECTRONIC_CODE;
                default: begin
                    src = rd_byte;
                    n.rd_next = q.cnt == 3'h0;
                end
            endcase
            ob = (q.cnt == 3'h0) ? src : q.sh;
            if (q.cnt == 3'h0) begin
                n.oidx = (q.oidx == 2'h3) ? q.oidx : q.oidx + 2'h1;
            end
            case (q.lane)
                3'h4: begin
                    n.out = ob[7:4];
                    n.oe = OE_FOUR;
                    n.sh = {ob[3:0], 4'h0};
                end
                3'h2: begin
                    n.out = {2'h0, ob[7:6]};
                    n.oe = OE_TWO;
                    n.sh = {ob[5:0], 2'h0};
                end
                default: begin
                    n.out = {2'h0, ob[7], 1'b0};
                    n.oe = OE_ONE;
                    n.sh = {ob[6:0], 1'b0};
                end
            endcase
            n.cnt = last ? 3'h0 : q.cnt + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.st <= S_IDLE;
            q.cs_m <= 1'b1;
            q.cs_r <= 1'b1;
            q.cs_p <= 1'b1;
            q.lane <= 3'h1;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // outputs
    assign io_out = q.out;
    assign io_oe = q.oe;
    assign rd_next = q.rd_next;
    assign cmd_valid = q.cmd_vld;
    assign cmd = '{opcode: q.opc, addr: q.addr};
    assign wr_valid = q.hv;
    assign wr_byte = q.hd;
    assign overrun = q.ovr;
    assign write_latch = q.wel;
    assign vsr_unlock = q.vsr;
    assign all_protect = q.prot;
    assign sleeping = q.sleep;
    assign four_lane_cmd = q.qmode;
    assign busy = q.busy;

    // ==========================================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    latch_set_a: assert property (ex_ok && q.opc == OPC_WRITE_LATCH_SET |=> write_latch)
        else $error("write latch not set");
    latch_clear_a: assert property (ex_ok && q.opc == OPC_WRITE_LATCH_CLEAR
        |=> !write_latch)
        else $error("write latch not cleared");
    protect_all_a: assert property (ex_ok && q.opc == OPC_ALL_BLOCK_PROTECT
        |=> all_protect)
        else $error("global protect missed");
    sleep_entry_a: assert property (ex_ok && q.opc == OPC_SLEEP_MODE_ENTRY |=> sleeping)
        else $error("sleep not entered");
    reset_busy_a: assert property (ex_ok && q.opc == OPC_SOFT_RESET_GO && q.arm
        |=> busy [*8])
        else $error("soft reset not busy");
    busy_refuse_a: assert property (busy && q.st == S_IDLE && !q.cs_r |=> q.st == S_STBY)
        else $error("command taken while busy");
    standby_quiet_a: assert property (q.st == S_STBY |-> io_oe == 4'h0)
        else $error("output driven in standby");
    partial_drop_a: assert property (cs_rise && q.cnt != 3'h0 |=> !cmd_valid)
        else $error("partial byte executed");
    quad_gate_a: assert property (q.st == S_OPC && !quad_lane_permit_bit && rise && last
        && sfcd_decode(ib, alt_dummy).quad |=> q.st == S_STBY)
        else $error("quad command without permit");
    quad_lanes_a: assert property (q.st == S_DOUT && io_oe != 4'h0
        && q.opc == OPC_FOUR_LANE_OUT_FETCH |-> io_oe == OE_FOUR)
        else $error("quad read not on four lanes");
    unknown_stby_a: assert property (!q.cs_r && q.st == S_OPC && rise && last && !d.known
        |=> q.st == S_STBY)
        else $error("unknown opcode taken");
    unprotect_all_a: assert property (ex_ok && q.opc == OPC_ALL_BLOCK_UNPROTECT
        |=> !all_protect)
        else $error("global unprotect missed");

    read_start_c: cover property (q.st == S_DOUT && fall);
    write_push_c: cover property (wr_valid && !wr_ready ##1 q.tv);
    soft_reset_c: cover property ($rose(busy));
    standby_c: cover property (q.st == S_OPC ##1 q.st == S_STBY);
endmodule : sfcd_decoder

/* sfcd_host.sv */
// host model driving the serial link of the command decoder
`timescale 1ns/1ps
module sfcd_host (
    input wire logic clk,
    input wire logic [3:0] io_out,
    output logic sclk,
    output logic cs_n,
    output logic [3:0] io_drv
);
    // ==========
    // idle: clock still and low, select off
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io_drv = 4'h5;
    end
    // ==========
    // select edges four clocks after the clock is pulled low, whatever the bit count
    task automatic frame(input logic on);
        @(negedge clk);
        sclk = 1'b0;
        repeat (4) @(negedge clk);
        cs_n = ~on;
        io_drv = ~io_drv;
        repeat (4) @(negedge clk);
    endtask : frame
    // ==========
    // n clocks on w lanes, msb first; released lanes toggle
    task automatic shift(input int w, input int n, input logic drv, input logic [31:0] tx,
                         output logic [31:0] rx);
        rx = 32'h0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            sclk = 1'b0;
            io_drv = drv ? 4'(tx[31:28] >> (4 - w)) : ~io_drv;
            tx = tx << w;
            repeat (4) @(negedge clk);
            rx = (rx << w) | ((w == 1) ? 32'(io_out[1]) : 32'(io_out & 4'((1 << w) - 1)));
            sclk = 1'b1;
            repeat (3) @(negedge clk);
        end
    endtask : shift
endmodule : sfcd_host

/* sfcd_decoder_bench.sv */
// self-checking bench of the serial flash command decoder
`timescale 1ns/1ps
module sfcd_decoder_bench;
    import sfcd_pkg::*;
    localparam int RCYC = 20;
    localparam logic [23:0] ADR = 24'h0A5C3E;
    localparam logic [7:0] NOADR [8] = '{8'h60, 8'hC7, 8'h75, 8'h7A, 8'h9E, 8'h98, 8'h50, 8'h7E};
    localparam logic [7:0] WADR [10] = '{8'h81, 8'h20, 8'h52, 8'hD8, 8'h36, 8'h39, 8'h3D,
                                         8'h44, 8'h9A, 8'h9D};
    localparam logic [7:0] DOP [6] = '{8'h01, 8'h31, 8'h11, 8'h42, 8'h9C, 8'h32};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic permit = 1'b1;
    logic alt = 1'b0;
    logic wr_ready = 1'b1;
    logic sclk, cs_n, rd_next, cmd_valid, wr_valid, overrun;
    logic write_latch, vsr_unlock, all_protect, sleeping, four_lane_cmd, busy;
    logic [3:0] io_drv, io_out, io_oe, io_in;
    logic [7:0] wr_byte;
    logic [7:0] rdc = 8'h00;
    logic [31:0] rx;
    sfcd_cmd_t cmd, got;
    int err_total = 0;
    int cmp_count = 0;
    int ncmd = 0;
    wire [7:0] rd_byte = 8'hC3 + rdc;
    assign io_in = (io_drv & ~io_oe) | (io_out & io_oe);
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (rd_next === 1'b1) rdc <= rdc + 8'h01;
        if (cmd_valid === 1'b1) begin
            ncmd++;
            got <= cmd;
        end
    end
    sfcd_host sfcd_host_i (.clk(clk), .io_out(io_out), .sclk(sclk), .cs_n(cs_n), .io_drv(io_drv));
    sfcd_decoder #(.RESET_CYC(RCYC)) sfcd_decoder_i (
        .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe), .quad_lane_permit_bit(permit), .alt_dummy(alt),
        .stat_primary(8'h1E), .stat_second(8'h2D), .config_byte(8'h4B), .rd_byte(rd_byte),
        .rd_next(rd_next), .cmd_valid(cmd_valid), .cmd(cmd), .wr_valid(wr_valid),
        .wr_byte(wr_byte), .wr_ready(wr_ready), .overrun(overrun), .write_latch(write_latch),
        .vsr_unlock(vsr_unlock), .all_protect(all_protect), .sleeping(sleeping),
        .four_lane_cmd(four_lane_cmd), .busy(busy));
    // ==========
    // compare, verdict and link helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic fr(input logic on);
        sfcd_host_i.frame(on);
    endtask : fr
    task automatic sh(input int w, input int n, input logic d, input logic [31:0] t);
        sfcd_host_i.shift(w, n, d, t, rx);
    endtask : sh
    task automatic rst();
        @(negedge clk);
        reset = 1'b1;
        wr_ready = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        repeat (3) @(negedge clk);
        check("reset state", {overrun, write_latch, busy, sleeping, io_oe}, 32'h0);
    endtask : rst
    // ==========
    // scenarios
    task automatic wr_cmd(input logic [7:0] op, input logic adr, input int extra);
        int n0;
        n0 = ncmd;
        fr(1'b1);
        sh(1, 8, 1'b1, {op, 24'h0});
        if (adr) sh(1, 24, 1'b1, {ADR, 8'h0});
        if (extra > 0) sh(1, extra, 1'b1, 32'hFFFFFFFF);
        fr(1'b0);
        if (extra >= 0) check("launches", 32'(ncmd - n0), (extra > 0) ? 0 : 1);
        if (extra == 0) check("opcode", got.opcode, op);
        if (extra == 0 && adr) check("address", got.addr, ADR);
    endtask : wr_cmd
    task automatic rd_cmd(input logic [7:0] op, input int al, input int dn, input int dl,
                          input logic [7:0] e0, input logic ok);
        logic [7:0] b;
        logic [3:0] e;
        int n0;
        b = rd_byte;
        n0 = ncmd;
        e = !ok ? 4'h0 : (dl == 1) ? OE_ONE : (dl == 2) ? OE_TWO : OE_FOUR;
        fr(1'b1);
        sh(1, 8, 1'b1, {op, 24'h0});
        if (al > 0) sh(al, 24 / al, 1'b1, {ADR, 8'h0});
        if (dn > 0) sh(al, dn * 8 / al, 1'b1, 32'h0);
        sh(dl, 16 / dl, 1'b0, 32'h0);
        check("lane enable", io_oe, e);
        fr(1'b0);
        check("read launch", 32'(ncmd - n0), 32'(ok));
        if (ok) check("read opcode", got.opcode, op);
        if (ok && al > 0) check("read address", got.addr, ADR);
        if (ok && e0 == 8'h00) check("stream", rx[15:0], {b, b + 8'h01});
        if (ok && e0 != 8'h00) check("one byte", rx[15:8], e0);
    endtask : rd_cmd
    task automatic prog_stall();
        @(negedge clk);
        wr_ready = 1'b0;
        fr(1'b1);
        sh(1, 8, 1'b1, 32'h02000000);
        sh(1, 24, 1'b1, {ADR, 8'h0});
        sh(1, 24, 1'b1, 32'h11223300);
        fr(1'b0);
        check("program opcode", got.opcode, 8'h02);
        check("overrun", overrun, 1'b1);
        for (int k = 0; k < 2; k++) begin
            check("write head", {wr_valid, wr_byte}, (k == 1) ? 9'h122 : 9'h111);
            @(negedge clk);
            wr_ready = 1'b1;
            @(negedge clk);
            wr_ready = 1'b0;
        end
        check("buffer empty", wr_valid, 1'b0);
    endtask : prog_stall
    task automatic data_cmd(input logic [7:0] op, input logic adr, input int w);
        int n0;
        n0 = ncmd;
        @(negedge clk);
        wr_ready = 1'b0;
        fr(1'b1);
        sh(1, 8, 1'b1, {op, 24'h0});
        if (adr) sh(1, 24, 1'b1, {ADR, 8'h0});
        sh(w, 8 / w, 1'b1, 32'hA7000000);
        fr(1'b0);
        check("data launch", 32'(ncmd - n0), 1);
        check("data opcode", got.opcode, op);
        check("data byte", {wr_valid, wr_byte}, 9'h1A7);
        wr_ready = 1'b1;
    endtask : data_cmd
    initial begin
        #300000;
        err_total++;
        conclude();
    end
    initial begin
        rst();
        rd_cmd(8'h03, 1, 0, 1, 8'h00, 1'b1);
        rd_cmd(8'h0B, 1, 1, 1, 8'h00, 1'b1);
        rd_cmd(8'h3B, 1, 1, 2, 8'h00, 1'b1);
        rd_cmd(8'hBB, 2, 1, 2, 8'h00, 1'b1);
        rd_cmd(8'h6B, 1, 1, 4, 8'h00, 1'b1);
        rd_cmd(8'hEB, 4, 3, 4, 8'h00, 1'b1);
        rd_cmd(8'hE7, 4, 1, 4, 8'h00, 1'b1);
        rd_cmd(8'h48, 1, 1, 1, 8'h00, 1'b1);
        rd_cmd(8'h9B, 1, 1, 1, 8'h00, 1'b1);
        rd_cmd(8'h05, 0, 0, 1, 8'h1E, 1'b1);
        rd_cmd(8'h35, 0, 0, 1, 8'h2D, 1'b1);
        rd_cmd(8'h15, 0, 0, 1, 8'h4B, 1'b1);
        rd_cmd(8'h9F, 0, 0, 1, MAKER_CODE, 1'b1);
        rd_cmd(8'h90, 1, 0, 1, MAKER_CODE, 1'b1);
        rd_cmd(8'h92, 1, 1, 2, MAKER_CODE, 1'b1);
        rd_cmd(8'h94, 1, 1, 4, MAKER_CODE, 1'b1);
        alt = 1'b1;
        rd_cmd(8'hBB, 2, 2, 2, 8'h00, 1'b1);
        rd_cmd(8'hEB, 4, 5, 4, 8'h00, 1'b1);
        alt = 1'b0;
        permit = 1'b0;
        rd_cmd(8'hEB, 4, 3, 4, 8'h00, 1'b0);
        permit = 1'b1;
        rd_cmd(8'hA5, 1, 0, 1, 8'h00, 1'b0);
        for (int i = 0; i < 8; i++) wr_cmd(NOADR[i], 1'b0, 0);
        check("protect all", {vsr_unlock, all_protect}, 2'b11);
        wr_cmd(8'h98, 1'b0, 0);
        check("unprotect all", all_protect, 1'b0);
        for (int i = 0; i < 10; i++) wr_cmd(WADR[i], 1'b1, 0);
        wr_cmd(8'h20, 1'b1, 4);
        wr_cmd(8'h06, 1'b0, 3);
        check("latch kept", write_latch, 1'b0);
        wr_cmd(8'h06, 1'b0, 0);
        check("latch set", write_latch, 1'b1);
        wr_cmd(8'h04, 1'b0, 0);
        check("latch clear", write_latch, 1'b0);
        wr_cmd(8'h38, 1'b0, 0);
        check("four lane on", four_lane_cmd, 1'b1);
        wr_cmd(8'hFF, 1'b0, 0);
        check("four lane off", four_lane_cmd, 1'b0);
        wr_cmd(8'hB9, 1'b0, 0);
        check("asleep", sleeping, 1'b1);
        rd_cmd(8'h05, 0, 0, 1, 8'h1E, 1'b0);
        rd_cmd(8'hAB, 1, 0, 1, ELECTRONIC_CODE, 1'b1);
        check("awake", sleeping, 1'b0);
        foreach (DOP[i]) data_cmd(DOP[i], i > 2, (i == 5) ? 4 : 1);
        prog_stall();
        rst();
        wr_cmd(8'h06, 1'b0, 0);
        wr_cmd(8'h99, 1'b0, -1);
        check("lone reset", {busy, write_latch}, 2'b01);
        wr_cmd(8'h66, 1'b0, 0);
        wr_cmd(8'h99, 1'b0, 0);
        check("resetting", {busy, write_latch}, 2'b10);
        rd_cmd(8'h05, 0, 0, 1, 8'h1E, 1'b0);
        check("reset done", busy, 1'b0);
        conclude();
    end
endmodule : sfcd_decoder_bench
